/* pei_event_irq_bank.sv */
// Purpose: Event and interrupt-enable registers behind a two-wire serial target
// Assumes: SCL is driven by the host only; no clock stretching
// Notes:   Register pointer auto-increments within the bank after each data byte
`timescale 1ns/100ps
module pei_event_irq_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic batt_volt_meas_done,
  input wire logic thermistor_meas_done,
  input wire logic die_temp_meas_done,
  input wire logic sys_volt_meas_done,
  input wire logic outsel1_pin_meas_done,
  input wire logic outsel2_pin_meas_done,
  input wire logic batt_current_meas_done,
  input wire logic bus_volt_meas_done,
  input wire logic battery_cold,
  input wire logic battery_cool,
  input wire logic battery_warm,
  input wire logic battery_hot,
  input wire logic die_temp_high,
  input wire logic die_temp_resume,
  input wire logic supplement_active,
  input wire logic trickle_started,
  input wire logic const_current_started,
  input wire logic const_voltage_started,
  input wire logic charge_done,
  input wire logic charge_fault,
  output logic irq
);
  import pei_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  pei_twi_state_t state_ff;
  logic scl_s;
  logic sda_s;
  logic scl_prev_ff;
  logic sda_prev_ff;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [3:0] bit_cnt_ff;
  logic [BYTE_W-1:0] shift_ff;
  logic rw_ff;
  logic nack_ff;
  logic [1:0] byte_idx_ff;
  logic [15:0] ptr_ff;
  logic wr_stb_ff;
  logic [BYTE_W-1:0] wr_off_ff;
  logic [BYTE_W-1:0] wr_data_ff;
  logic [BYTE_W-1:0] rd_data;
  logic [MEAS_W-1:0] meas_hw;
  logic [TEMP_W-1:0] temp_hw;
  logic [STAT_W-1:0] stat_hw;
  logic [MEAS_W-1:0] meas_ev;
  logic [MEAS_W-1:0] meas_en;
  logic [TEMP_W-1:0] temp_ev;
  logic [TEMP_W-1:0] temp_en;
  logic [STAT_W-1:0] stat_ev;
  logic [STAT_W-1:0] stat_en;
  logic meas_pend;
  logic temp_pend;
  logic stat_pend;

  // Write strobe decode, used for every register of every group
  function automatic logic wr_hit(input logic stb, input logic [BYTE_W-1:0] off,
                                  input logic [BYTE_W-1:0] target);
    wr_hit = stb && (off == target);
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers and bus condition detection
  // ----------------------------------------------------------------------
  pei_pin_sync u_scl_sync (
    .clk(clk),
    .rst(rst),
    .pin_in(scl_in),
    .pin_out(scl_s)
  );

  pei_pin_sync u_sda_sync (
    .clk(clk),
    .rst(rst),
    .pin_in(sda_in),
    .pin_out(sda_s)
  );

  // Previous filtered levels for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
    end
  end

  // SDA moving while SCL is high marks start and stop
  assign scl_rise = scl_s && !scl_prev_ff;
  assign scl_fall = !scl_s && scl_prev_ff;
  assign bus_start = scl_s && scl_prev_ff && sda_prev_ff && !sda_s;
  assign bus_stop = scl_s && scl_prev_ff && !sda_prev_ff && sda_s;

  // Open-drain pin: only ever pulls low
  assign sda_out = SDA_DRIVE_LVL;

  // ----------------------------------------------------------------------
  // Serial target state machine
  // ----------------------------------------------------------------------
  // Data and ack are changed on SCL fall so they are stable for the rise
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= PEI_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= REG_RESET;
      rw_ff <= 1'b0;
      nack_ff <= 1'b0;
      byte_idx_ff <= IDX_ADDR_HI;
      ptr_ff <= 16'h0000;
      sda_oe_n <= 1'b1;
      wr_stb_ff <= 1'b0;
      wr_off_ff <= REG_RESET;
      wr_data_ff <= REG_RESET;
    end else begin
      wr_stb_ff <= 1'b0;
      if (bus_start) begin
        // Repeated start keeps the pointer so a read follows an address write
        state_ff <= PEI_ADDR;
        bit_cnt_ff <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (bus_stop) begin
        state_ff <= PEI_IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        unique case (state_ff)
          PEI_ADDR, PEI_RX: begin
            shift_ff <= {shift_ff[BYTE_W-2:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          PEI_ACK_TX: begin
            nack_ff <= sda_s;
          end
          PEI_IDLE, PEI_ACK_ADDR, PEI_ACK_RX, PEI_TX: begin
          end
        endcase
      end else if (scl_fall) begin
        unique case (state_ff)
          PEI_ADDR: begin
            if (bit_cnt_ff == BITS_PER_BYTE) begin
              if (shift_ff[BYTE_W-1:1] == TWI_DEV_ADDR) begin
                sda_oe_n <= 1'b0;
                rw_ff <= shift_ff[0];
                state_ff <= PEI_ACK_ADDR;
              end else begin
                state_ff <= PEI_IDLE;
              end
            end
          end
          PEI_ACK_ADDR: begin
            if (rw_ff) begin
              // First read byte: drive msb now, offset steps after the load
              shift_ff <= {rd_data[BYTE_W-2:0], 1'b0};
              sda_oe_n <= rd_data[BYTE_W-1];
              bit_cnt_ff <= 4'h1;
              ptr_ff[7:0] <= ptr_ff[7:0] + 8'h01;
              state_ff <= PEI_TX;
            end else begin
              sda_oe_n <= 1'b1;
              byte_idx_ff <= IDX_ADDR_HI;
              bit_cnt_ff <= 4'h0;
              state_ff <= PEI_RX;
            end
          end
          PEI_RX: begin
            if (bit_cnt_ff == BITS_PER_BYTE) begin
              sda_oe_n <= 1'b0;
              state_ff <= PEI_ACK_RX;
              unique case (byte_idx_ff)
                IDX_ADDR_HI: begin
                  ptr_ff[15:8] <= shift_ff;
                  byte_idx_ff <= IDX_ADDR_LO;
                end
                IDX_ADDR_LO: begin
                  ptr_ff[7:0] <= shift_ff;
                  byte_idx_ff <= IDX_DATA;
                end
                default: begin
                  // Writes outside the main bank are acked and dropped
                  wr_stb_ff <= (ptr_ff[15:8] == MAIN_BANK);
                  wr_off_ff <= ptr_ff[7:0];
                  wr_data_ff <= shift_ff;
                  ptr_ff[7:0] <= ptr_ff[7:0] + 8'h01;
                end
              endcase
            end
          end
          PEI_ACK_RX: begin
            sda_oe_n <= 1'b1;
            bit_cnt_ff <= 4'h0;
            state_ff <= PEI_RX;
          end
          PEI_TX: begin
            if (bit_cnt_ff == BITS_PER_BYTE) begin
              sda_oe_n <= 1'b1;
              state_ff <= PEI_ACK_TX;
            end else begin
              sda_oe_n <= shift_ff[BYTE_W-1];
              shift_ff <= {shift_ff[BYTE_W-2:0], 1'b0};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
          end
          PEI_ACK_TX: begin
            if (nack_ff) begin
              // Host is done reading; wait for stop with the line released
              state_ff <= PEI_IDLE;
            end else begin
              shift_ff <= {rd_data[BYTE_W-2:0], 1'b0};
              sda_oe_n <= rd_data[BYTE_W-1];
              bit_cnt_ff <= 4'h1;
              ptr_ff[7:0] <= ptr_ff[7:0] + 8'h01;
              state_ff <= PEI_TX;
            end
          end
          PEI_IDLE: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data: set and clear registers of a pair both show live state
  // ----------------------------------------------------------------------
  always_comb begin
    rd_data = REG_RESET;
    if (ptr_ff[15:8] == MAIN_BANK) begin
      unique case (ptr_ff[7:0])
        OFF_MEAS_EV_SET, OFF_MEAS_EV_CLR: rd_data = meas_ev;
        OFF_MEAS_EN_SET, OFF_MEAS_EN_CLR: rd_data = meas_en;
        OFF_TEMP_EV_SET, OFF_TEMP_EV_CLR: rd_data = {2'b00, temp_ev};
        OFF_TEMP_EN_SET, OFF_TEMP_EN_CLR: rd_data = {2'b00, temp_en};
        OFF_STAT_EV_SET, OFF_STAT_EV_CLR: rd_data = {2'b00, stat_ev};
        OFF_STAT_EN_SET, OFF_STAT_EN_CLR: rd_data = {2'b00, stat_en};
        default: rd_data = REG_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Hardware event sources, packed in bit order
  // ----------------------------------------------------------------------
  assign meas_hw = {bus_volt_meas_done, batt_current_meas_done, outsel2_pin_meas_done,
                    outsel1_pin_meas_done, sys_volt_meas_done, die_temp_meas_done,
                    thermistor_meas_done, batt_volt_meas_done};
  assign temp_hw = {die_temp_resume, die_temp_high, battery_hot, battery_warm,
                    battery_cool, battery_cold};
  assign stat_hw = {charge_fault, charge_done, const_voltage_started, const_current_started,
                    trickle_started, supplement_active};

  // ----------------------------------------------------------------------
  // Event groups; upper data bits are simply not connected to 6-bit groups
  // ----------------------------------------------------------------------
  pei_event_group #(.W(MEAS_W)) u_meas (
    .clk(clk),
    .rst(rst),
    .hw_set(meas_hw),
    .ev_set_wr(wr_hit(wr_stb_ff, wr_off_ff, OFF_MEAS_EV_SET)),
    .ev_clr_wr(wr_hit(wr_stb_ff, wr_off_ff, OFF_MEAS_EV_CLR)),
    .en_set_wr(wr_hit(wr_stb_ff, wr_off_ff, OFF_MEAS_EN_SET)),
    .en_clr_wr(wr_hit(wr_stb_ff, wr_off_ff, OFF_MEAS_EN_CLR)),
    .wdata(wr_data_ff),
    .events_ff(meas_ev),
    .enables_ff(meas_en),
    .pending(meas_pend)
  );

  pei_event_group #(.W(TEMP_W)) u_temp (
    .clk(clk),
    .rst(rst),
    .hw_set(temp_hw),
    .ev_set_wr(wr_hit(wr_stb_ff, wr_off_ff, OFF_TEMP_EV_SET)),
    .ev_clr_wr(wr_hit(wr_stb_ff, wr_off_ff, OFF_TEMP_EV_CLR)),
    .en_set_wr(wr_hit(wr_stb_ff, wr_off_ff, OFF_TEMP_EN_SET)),
    .en_clr_wr(wr_hit(wr_stb_ff, wr_off_ff, OFF_TEMP_EN_CLR)),
    .wdata(wr_data_ff[TEMP_W-1:0]),
    .events_ff(temp_ev),
    .enables_ff(temp_en),
    .pending(temp_pend)
  );

  pei_event_group #(.W(STAT_W)) u_stat (
    .clk(clk),
    .rst(rst),
    .hw_set(stat_hw),
    .ev_set_wr(wr_hit(wr_stb_ff, wr_off_ff, OFF_STAT_EV_SET)),
    .ev_clr_wr(wr_hit(wr_stb_ff, wr_off_ff, OFF_STAT_EV_CLR)),
    .en_set_wr(wr_hit(wr_stb_ff, wr_off_ff, OFF_STAT_EN_SET)),
    .en_clr_wr(wr_hit(wr_stb_ff, wr_off_ff, OFF_STAT_EN_CLR)),
    .wdata(wr_data_ff[STAT_W-1:0]),
    .events_ff(stat_ev),
    .enables_ff(stat_en),
    .pending(stat_pend)
  );

  // ----------------------------------------------------------------------
  // Interrupt request, registered to keep the output glitch free
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= meas_pend | temp_pend | stat_pend;
    end
  end
endmodule // pei_event_irq_bank

/* pei_pkg.sv */
// Purpose: Shared constants for the event and interrupt-enable register bank
// Assumes: 200 MHz system clock, serial register port with 16-bit addresses
// Notes:   Offsets are within the main bank; measurement registers are 8 bits wide, temperature and status 6
package pei_pkg;

  // ----------------------------------------------------------------------
  // Serial port identity and framing
  // ----------------------------------------------------------------------
  localparam logic [6:0] TWI_DEV_ADDR = 7'h6B;
  localparam int BYTE_W = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] IDX_ADDR_HI = 2'h0;
  localparam logic [1:0] IDX_ADDR_LO = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  localparam logic [7:0] MAIN_BANK = 8'h00;
  localparam logic SDA_DRIVE_LVL = 1'b0;

  // ----------------------------------------------------------------------
  // Event group widths and register offsets
  // ----------------------------------------------------------------------
  localparam int MEAS_W = 8;
  localparam int TEMP_W = 6;
  localparam int STAT_W = 6;
  localparam logic [7:0] OFF_MEAS_EV_SET = 8'h02;
  localparam logic [7:0] OFF_MEAS_EV_CLR = 8'h03;
  localparam logic [7:0] OFF_MEAS_EN_SET = 8'h04;
  localparam logic [7:0] OFF_MEAS_EN_CLR = 8'h05;
  localparam logic [7:0] OFF_TEMP_EV_SET = 8'h06;
  localparam logic [7:0] OFF_TEMP_EV_CLR = 8'h07;
  localparam logic [7:0] OFF_TEMP_EN_SET = 8'h08;
  localparam logic [7:0] OFF_TEMP_EN_CLR = 8'h09;
  localparam logic [7:0] OFF_STAT_EV_SET = 8'h0A;
  localparam logic [7:0] OFF_STAT_EV_CLR = 8'h0B;
  localparam logic [7:0] OFF_STAT_EN_SET = 8'h0C;
  localparam logic [7:0] OFF_STAT_EN_CLR = 8'h0D;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Serial target states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PEI_IDLE,
    PEI_ADDR,
    PEI_ACK_ADDR,
    PEI_RX,
    PEI_ACK_RX,
    PEI_TX,
    PEI_ACK_TX
  } pei_twi_state_t;

endpackage

/* pei_pin_sync.sv */
// Purpose: Three-flop pin synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes:   Output only moves when the second and third stages agree
`timescale 1ns/100ps
module pei_pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic pin_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // ----------------------------------------------------------------------
  // Sync chain; reset to the idle-high bus level
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Filtered level; a one-sample glitch never reaches the target
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= 1'b1;
    end else if (s2_ff == s3_ff) begin
      pin_out <= s3_ff;
    end
  end
endmodule // pei_pin_sync

/* pei_event_group.sv */
// Purpose: One event group: sticky events plus interrupt enables
// Assumes: Write strobes are single-cycle pulses on the system clock
// Notes:   Hardware and debug sets win over a clear in the same cycle
`timescale 1ns/100ps
module pei_event_group #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] hw_set,
  input wire logic ev_set_wr,
  input wire logic ev_clr_wr,
  input wire logic en_set_wr,
  input wire logic en_clr_wr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] events_ff,
  output logic [W-1:0] enables_ff,
  output logic pending
);
  logic [W-1:0] nxt_events;
  logic [W-1:0] nxt_enables;

  // ----------------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_events = events_ff;
    if (ev_clr_wr) begin
      nxt_events = nxt_events & ~wdata;
    end
    if (ev_set_wr) begin
      nxt_events = nxt_events | wdata;
    end
    nxt_events = nxt_events | hw_set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      events_ff <= '0;
    end else begin
      events_ff <= nxt_events;
    end
  end

  // ----------------------------------------------------------------------
  // Enables; clearing one leaves its pending event untouched
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_enables = enables_ff;
    if (en_clr_wr) begin
      nxt_enables = nxt_enables & ~wdata;
    end
    if (en_set_wr) begin
      nxt_enables = nxt_enables | wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enables_ff <= '0;
    end else begin
      enables_ff <= nxt_enables;
    end
  end

  // Any enabled event still pending
  assign pending = |(events_ff & enables_ff);
endmodule // pei_event_group

/* pei_bank_sva.sv */
// Purpose: Port-level assertions for the event and interrupt register bank
// Assumes: Host holds each SCL phase for at least 10 clocks
// Notes:   Helper counters age SCL edges; no internal signal is watched
`timescale 1ns/100ps
module pei_bank_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic batt_volt_meas_done,
  input wire logic thermistor_meas_done,
  input wire logic die_temp_meas_done,
  input wire logic sys_volt_meas_done,
  input wire logic outsel1_pin_meas_done,
  input wire logic outsel2_pin_meas_done,
  input wire logic batt_current_meas_done,
  input wire logic bus_volt_meas_done,
  input wire logic battery_cold,
  input wire logic battery_cool,
  input wire logic battery_warm,
  input wire logic battery_hot,
  input wire logic die_temp_high,
  input wire logic die_temp_resume,
  input wire logic supplement_active,
  input wire logic trickle_started,
  input wire logic const_current_started,
  input wire logic const_voltage_started,
  input wire logic charge_done,
  input wire logic charge_fault,
  input wire logic irq
);
  logic scl_q_ff;
  logic [7:0] fall_age_ff;
  logic [7:0] hi_cnt_ff;
  logic hw_any;
  // Any hardware event; besides a register write the only way irq can rise
  assign hw_any = batt_volt_meas_done | thermistor_meas_done | die_temp_meas_done | sys_volt_meas_done |
    outsel1_pin_meas_done | outsel2_pin_meas_done | batt_current_meas_done | bus_volt_meas_done |
    battery_cold | battery_cool | battery_warm | battery_hot | die_temp_high | die_temp_resume |
    supplement_active | trickle_started | const_current_started | const_voltage_started | charge_done | charge_fault;
  // Saturating ages: register writes only land a few clocks after an SCL fall
  always_ff @(posedge clk) begin
    scl_q_ff <= scl_in;
    if (rst) fall_age_ff <= 8'hFF;
    else if (scl_q_ff && !scl_in) fall_age_ff <= 8'h00;
    else if (fall_age_ff != 8'hFF) fall_age_ff <= fall_age_ff + 8'h01;
    if (rst || !scl_in) hi_cnt_ff <= 8'h00;
    else if (hi_cnt_ff != 8'hFF) hi_cnt_ff <= hi_cnt_ff + 8'h01;
  end
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_drive_low_only; sda_out == 1'b0; endproperty
  a_drive_low_only: assert property (p_drive_low_only) else $error("sda_out not low");
  property p_quiet_after_reset; $past(rst) |-> !irq && sda_oe_n; endproperty
  a_quiet_after_reset: assert property (p_quiet_after_reset) else $error("irq or sda after reset");
  property p_no_early_ack; $fell(rst) |-> sda_oe_n [*8]; endproperty
  a_no_early_ack: assert property (p_no_early_ack) else $error("sda driven right after reset");
  property p_irq_rise_cause; $rose(irq) |-> $past(hw_any) || $past(hw_any, 2) || $past(hw_any, 3) ||
    fall_age_ff < 8'h14; endproperty
  a_irq_rise_cause: assert property (p_irq_rise_cause) else $error("irq rose without cause");
  property p_irq_fall_cause; $fell(irq) |-> fall_age_ff < 8'h14; endproperty
  a_irq_fall_cause: assert property (p_irq_fall_cause) else $error("irq fell without a write");
  property p_sda_moves_scl_low; $changed(sda_oe_n) |-> !scl_in; endproperty
  a_sda_moves_scl_low: assert property (p_sda_moves_scl_low) else $error("sda moved while scl high");
  property p_drive_bounded; $fell(sda_oe_n) |-> ##[1:400] sda_oe_n; endproperty
  a_drive_bounded: assert property (p_drive_bounded) else $error("sda held low too long");
  property p_idle_released; hi_cnt_ff >= 8'h1E |-> sda_oe_n; endproperty
  a_idle_released: assert property (p_idle_released) else $error("sda driven on idle bus");
endmodule // pei_bank_sva

bind pei_event_irq_bank pei_bank_sva pei_bank_sva_inst (.*);

/* pei_host_model.sv */
// Purpose: Host controller model driving the two-wire register port
// Assumes: SDA has a pull-up; model only pulls low or releases
// Notes:   SCL low phase 16 clocks, high phase 10, to clear the pin filter
`timescale 1ns/100ps
module pei_host_model
  import pei_pkg::*;
(
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Every change lands just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send_bit(input logic b);
    sda_pull = !b;
    tick(8);
    scl = 1'b1;
    tick(10);
    scl = 1'b0;
    tick(8);
  endtask
  task automatic get_bit(output logic b);
    sda_pull = 1'b0;
    tick(8);
    scl = 1'b1;
    tick(5);
    b = sda_wire;
    tick(5);
    scl = 1'b0;
    tick(8);
  endtask
  // SDA falls with SCL high; also serves as repeated start
  task automatic start();
    sda_pull = 1'b0;
    tick(8);
    scl = 1'b1;
    tick(12);
    sda_pull = 1'b1;
    tick(12);
    scl = 1'b0;
    tick(8);
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    tick(8);
    scl = 1'b1;
    tick(12);
    sda_pull = 1'b0;
    tick(20);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) send_bit(d[i]);
    get_bit(a);
    ack = !a;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    send_bit(last);
  endtask
  // Bank byte first, then offset, then one data byte
  task automatic write_reg(input logic [7:0] bank, input logic [7:0] off, input logic [7:0] data,
      input logic [6:0] dev, output logic ok);
    logic a0, a1, a2, a3;
    start();
    put_byte({dev, 1'b0}, a0);
    put_byte(bank, a1);
    put_byte(off, a2);
    put_byte(data, a3);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask
  task automatic read_reg(input logic [7:0] bank, input logic [7:0] off, output logic [7:0] d, output logic ok);
    logic a0, a1, a2, a3;
    start();
    put_byte({TWI_DEV_ADDR, 1'b0}, a0);
    put_byte(bank, a1);
    put_byte(off, a2);
    start();
    put_byte({TWI_DEV_ADDR, 1'b1}, a3);
    get_byte(1'b1, d);
    stop();
    ok = a0 & a1 & a2 & a3;
  endtask
endmodule // pei_host_model

/* testbench.sv */
// Purpose: Self-checking bench for the event and interrupt register bank
// Assumes: Host model owns the bus; bench drives hardware event inputs
// Notes:   Reset values first, then table rows, then address, bank and hardware-set cases
`timescale 1ns/100ps
module testbench;
  import pei_pkg::*;
  typedef struct packed {
    logic [7:0] wo;
    logic [7:0] wd;
    logic [7:0] ro;
    logic [7:0] rd;
    logic ex_irq;
  } pei_row_t;
  localparam logic [19:0] HW_PAT = {6'h2A, 6'h15, 8'h5A};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [19:0] hw = 20'h00000;
  logic scl, sda_pull, sda_wire, sda_out, sda_oe_n, irq, ok;
  logic [7:0] rd;
  logic [19:0] pat;
  logic [7:0] grp [3];
  int n_errors = 0;
  int n_checks = 0;
  // Write offset, data, read offset, expected read, expected irq
  pei_row_t rows [13] = '{
    '{8'h02, 8'hA5, 8'h03, 8'hA5, 1'b0},
    '{8'h03, 8'h00, 8'h02, 8'hA5, 1'b0},
    '{8'h03, 8'h81, 8'h02, 8'h24, 1'b0},
    '{8'h04, 8'h0F, 8'h05, 8'h0F, 1'b1},
    '{8'h05, 8'h07, 8'h04, 8'h08, 1'b0},
    '{8'h06, 8'hFF, 8'h07, 8'h3F, 1'b0},
    '{8'h07, 8'h15, 8'h06, 8'h2A, 1'b0},
    '{8'h08, 8'hFF, 8'h09, 8'h3F, 1'b1},
    '{8'h09, 8'hFF, 8'h07, 8'h2A, 1'b0},
    '{8'h0A, 8'hFF, 8'h0B, 8'h3F, 1'b0},
    '{8'h0B, 8'h1F, 8'h0A, 8'h20, 1'b0},
    '{8'h0C, 8'h30, 8'h0D, 8'h30, 1'b1},
    '{8'h30, 8'hFF, 8'h30, 8'h00, 1'b1}
  };
  // Pull-up wire: any party pulling low wins
  assign sda_wire = !sda_pull && (sda_oe_n || sda_out);
  always #2.5 clk = ~clk;
  pei_host_model pei_host_model_inst (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));
  pei_event_irq_bank pei_event_irq_bank_inst (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .batt_volt_meas_done(hw[0]), .thermistor_meas_done(hw[1]), .die_temp_meas_done(hw[2]),
    .sys_volt_meas_done(hw[3]), .outsel1_pin_meas_done(hw[4]), .outsel2_pin_meas_done(hw[5]),
    .batt_current_meas_done(hw[6]), .bus_volt_meas_done(hw[7]), .battery_cold(hw[8]),
    .battery_cool(hw[9]), .battery_warm(hw[10]), .battery_hot(hw[11]), .die_temp_high(hw[12]),
    .die_temp_resume(hw[13]), .supplement_active(hw[14]), .trickle_started(hw[15]),
    .const_current_started(hw[16]), .const_voltage_started(hw[17]), .charge_done(hw[18]),
    .charge_fault(hw[19]), .irq(irq));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog sized beyond the roughly 65k clocks the sequence needs
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    $display("unexpected timeout: run did not finish");
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    pei_host_model_inst.tick(4);
    check("sda_oe_n", 8'h01, {7'h00, sda_oe_n});
    check("irq", 8'h00, {7'h00, irq});
    for (int o = 2; o < 14; o++) begin
      pei_host_model_inst.read_reg(MAIN_BANK, 8'(o), rd, ok);
      check("reset value", REG_RESET, rd);
    end
    foreach (rows[i]) begin
      pei_host_model_inst.write_reg(MAIN_BANK, rows[i].wo, rows[i].wd, TWI_DEV_ADDR, ok);
      check("write ack", 8'h01, {7'h00, ok});
      pei_host_model_inst.read_reg(MAIN_BANK, rows[i].ro, rd, ok);
      check("read ack", 8'h01, {7'h00, ok});
      check("read data", rows[i].rd, rd);
      check("row irq", {7'h00, rows[i].ex_irq}, {7'h00, irq});
    end
    // Foreign device address: no ack and the clear is lost
    pei_host_model_inst.write_reg(MAIN_BANK, OFF_STAT_EV_CLR, 8'hFF, TWI_DEV_ADDR ^ 7'h01, ok);
    check("foreign ack", 8'h00, {7'h00, ok});
    // Foreign bank: acknowledged yet dropped
    pei_host_model_inst.write_reg(8'h01, OFF_STAT_EV_CLR, 8'hFF, TWI_DEV_ADDR, ok);
    check("bank ack", 8'h01, {7'h00, ok});
    pei_host_model_inst.read_reg(MAIN_BANK, OFF_STAT_EV_SET, rd, ok);
    check("status after drops", 8'h20, rd);
    // Complementary patterns so each event bit is seen set and unset
    for (int p = 0; p < 2; p++) begin
      pat = (p == 0) ? HW_PAT : ~HW_PAT;
      for (int g = 0; g < 3; g++) pei_host_model_inst.write_reg(MAIN_BANK, 8'(3 + 4 * g), 8'hFF, TWI_DEV_ADDR, ok);
      check("irq cleared", 8'h00, {7'h00, irq});
      hw = pat;
      pei_host_model_inst.tick(1);
      hw = 20'h00000;
      pei_host_model_inst.tick(4);
      check("irq from hardware", 8'h01, {7'h00, irq});
      grp = '{pat[7:0], {2'b00, pat[13:8]}, {2'b00, pat[19:14]}};
      for (int g = 0; g < 3; g++) begin
        pei_host_model_inst.read_reg(MAIN_BANK, 8'(2 + 4 * g), rd, ok);
        check("hardware event", grp[g], rd);
      end
    end
    // Mid-run reset with an enabled status event pending: all state must go
    rst = 1'b1;
    pei_host_model_inst.tick(2);
    rst = 1'b0;
    pei_host_model_inst.tick(4);
    check("irq after reset", 8'h00, {7'h00, irq});
    pei_host_model_inst.read_reg(MAIN_BANK, OFF_STAT_EV_SET, rd, ok);
    check("event after reset", REG_RESET, rd);
    pei_host_model_inst.read_reg(MAIN_BANK, OFF_STAT_EN_SET, rd, ok);
    check("enable after reset", REG_RESET, rd);
    give_verdict();
  end
endmodule // testbench
